// *** rtl/boot_loader_regs.vh ***
`ifndef BOOT_LOADER_REGS_VH
`define BOOT_LOADER_REGS_VH

// register byte offsets
`define GC_CTRL_OFF        8'h00
`define GC_THRESH_OFF      8'h04
`define GC_STATUS_OFF      8'h08

// control word bit positions
`define CB_RTC_OFF_MASK    0
`define CB_SLOW_CLK_SEL    1
`define CB_KEEP_ON         2
`define CB_SLOT_SEL        3
`define CB_LP_OFF_EN       4
`define CB_LP_RST_EN       5
`define CB_IRQ_POL         6
`define CB_BAT_HI_MASK     7
`define CB_IN4_RISE_MASK   8
`define CB_IN4_FALL_MASK   9
`define CB_IN5_RISE_MASK   10
`define CB_IN5_FALL_MASK   11
`define CB_PIN0_OD_SEL     12
`define CB_WDOG_EN         13
`define CB_BUF_BYPASS      14
`define CB_AUTO_KEEP_ON    15
`define CB_PD_POL          16
`define CTRL_W             17

// fixed boot control word
`define CTRL_FIXED         17'h0_eab8

// threshold field in its register, and its width
`define THR_LSB            1
`define THR_MSB            5
`define THR_W              5

// eeprom word layout
`define EE_CTRL_MSB        16
`define EE_THR_LSB         24
`define EE_THR_MSB         28

// status bit positions
`define ST_LOAD_DONE       0
`define ST_MODE_LSB        1
`define ST_MODE_MSB        2
`define ST_PAD_EN          3
`define ST_AUTO_SET        4

// boot mode codes
`define MODE_FIXED         2'h0
`define MODE_EEPROM        2'h1
`define MODE_TEST          2'h2

// timing
`define CLK_MHZ            40
`define SLOT_SHORT_US      500
`define SLOT_LONG_US       2000
`define SLOT_CNT_W         17
`define SETTLE_CYCLES      4'h4
`define SETTLE_W           4

`endif

// *** rtl/boot_pin_sync.v ***
`timescale 1ns/100ps
`default_nettype none

module boot_pin_sync #(
  parameter WIDTH = 4
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // asynchronous pins and their synchronised copies
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;

  always @(posedge clk) begin
    if (rst) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;

endmodule // boot_pin_sync

`default_nettype wire

// *** rtl/boot_word_fetch.v ***
`timescale 1ns/100ps
`default_nettype none

module boot_word_fetch (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // loader side
  input  wire        start,
  output wire [31:0] word,
  output wire        done,
  // eeprom side
  output wire        eeprom_req,
  input  wire        eeprom_ack,
  input  wire [31:0] eeprom_data
);

  reg        req_q;
  reg        done_q;
  reg [31:0] word_q;

  // request held until the eeprom acknowledges with data
  always @(posedge clk) begin
    if (rst) begin
      req_q  <= 1'b0;
      done_q <= 1'b0;
      word_q <= 32'h0000_0000;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        req_q <= 1'b1;
      end else if (req_q && eeprom_ack) begin
        req_q  <= 1'b0;
        done_q <= 1'b1;
        word_q <= eeprom_data;
      end
    end
  end

  assign eeprom_req = req_q;
  assign word       = word_q;
  assign done       = done_q;

endmodule // boot_word_fetch

`default_nettype wire

// *** rtl/boot_general_control_loader.v ***
// Summary of operation
// RULE1 - boot pin low fixed, high eeprom
// RULE2 - disable boot pin pad after sampling
// RULE3 - rtc regulator off mask, fixed 0
// RULE4 - slow clock source select, fixed crystal
// RULE5 - keep on holds device on, fixed 0
// RULE6 - slot 0.5 ms or 2 ms, fixed 2
// RULE7 - long press power off enable, fixed 1
// RULE8 - long press core reset enable, fixed 1
// RULE9 - interrupt polarity, fixed active low
// RULE10 - battery high mask gates auto switch on
// RULE11 - edge mask bits suppress input interrupts
// RULE12 - fixed: fall masked, rise unmasked
// RULE13 - pin zero push-pull or open-drain
// RULE14 - watchdog enable, fixed 1
// RULE15 - battery monitor buffer bypass, fixed bypass
// RULE16 - five bit threshold at bits 5:1
// RULE17 - auto keep on: hold pin input
// RULE18 - power down input polarity, fixed low
// RULE19 - load values before first slot, writable
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "boot_loader_regs.vh"

module boot_general_control_loader #(
  parameter [`THR_W-1:0]      FIXED_THRESHOLD   = 5'h0c,
  parameter [`SLOT_CNT_W-1:0] SLOT_SHORT_CYCLES =
    `SLOT_SHORT_US * `CLK_MHZ,
  parameter [`SLOT_CNT_W-1:0] SLOT_LONG_CYCLES  =
    `SLOT_LONG_US * `CLK_MHZ
) (
  // clock and reset
  input  wire                   clk,
  input  wire                   rst,
  // apb slave
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [7:0]             paddr,
  input  wire [31:0]            pwdata,
  input  wire [3:0]             pstrb,
  output wire [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  // boot selection pad
  input  wire                   boot_select_pin,
  input  wire                   boot_pin_floating,
  output wire                   boot_pad_enable,
  // eeprom
  output wire                   eeprom_req,
  input  wire                   eeprom_ack,
  input  wire [31:0]            eeprom_data,
  // sequencer
  output wire                   load_done,
  output wire [`SLOT_CNT_W-1:0] slot_length_cycles,
  input  wire                   reset_output_level,
  // control bits
  output wire                   rtc_regulator_off_mask,
  output wire                   slow_clock_source_select,
  output wire                   keep_device_on,
  output wire                   slot_duration_select,
  output wire                   long_press_power_off_enable,
  output wire                   long_press_core_reset_enable,
  output wire                   interrupt_polarity_select,
  output wire                   battery_high_switch_on_mask,
  output wire                   input_four_rise_mask,
  output wire                   input_four_fall_mask,
  output wire                   input_five_rise_mask,
  output wire                   input_five_fall_mask,
  output wire                   pin_zero_open_drain_select,
  output wire                   watchdog_enable,
  output wire                   battery_monitor_buffer_bypass,
  output wire [`THR_W-1:0]      battery_gate_threshold,
  output wire                   auto_keep_on_select,
  output wire                   power_down_input_polarity,
  // interrupt output pin
  input  wire                   irq_pending,
  output wire                   interrupt_output,
  // switch-on and input edge events
  input  wire                   battery_high_event,
  output wire                   switch_on_request,
  input  wire                   input_four_rise_event,
  input  wire                   input_four_fall_event,
  input  wire                   input_five_rise_event,
  input  wire                   input_five_fall_event,
  output wire                   input_four_rise_irq,
  output wire                   input_four_fall_irq,
  output wire                   input_five_rise_irq,
  output wire                   input_five_fall_irq,
  // pin zero driver
  input  wire                   pin_zero_level,
  output wire                   pin_zero_out,
  output wire                   pin_zero_oe,
  // hold pin
  input  wire                   supply_hold_pin,
  output wire                   hold_request,
  output wire                   hold_gpi_level,
  // power down reset input
  input  wire                   power_down_reset_input,
  output wire                   power_down_active
);

  localparam ST_SETTLE = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_FETCH  = 2'h2;
  localparam ST_DONE   = 2'h3;
  function [31:0] merge_lanes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer      i;
    begin
      merge_lanes = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge_lanes[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction
  function apply_pol;
    input level;
    input active_high;
    begin
      apply_pol = active_high ? level : ~level;
    end
  endfunction
  // synchronised pins
  wire [3:0] pins_s;
  wire       boot_pin_s   = pins_s[0];
  wire       boot_float_s = pins_s[1];
  wire       pd_pin_s     = pins_s[2];
  wire       hold_pin_s   = pins_s[3];
  boot_pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({supply_hold_pin, power_down_reset_input,
           boot_pin_floating, boot_select_pin}),
    .q   (pins_s)
  );
  reg  [1:0]            state_q;
  reg  [1:0]            state_d;
  reg  [`SETTLE_W-1:0]  settle_q;
  reg  [1:0]            mode_q;
  reg                   pad_en_q;
  reg                   done_q;
  reg                   auto_set_q;
  reg  [`CTRL_W-1:0]    ctrl_q;
  reg  [`CTRL_W-1:0]    ctrl_d;
  reg  [`THR_W-1:0]     thr_q;
  reg  [`THR_W-1:0]     thr_d;
  reg  [31:0]           prdata_q;
  reg                   rst_out_q;
  reg  [`SLOT_CNT_W-1:0] slot_q;
  reg                   irq_out_q;
  reg                   sw_on_q;
  reg  [3:0]            edge_irq_q;
  reg                   pin0_out_q;
  reg                   pin0_oe_q;
  reg                   hold_req_q;
  reg                   hold_gpi_q;
  reg                   pd_act_q;
  wire                  fetch_start = (state_q == ST_SAMPLE) &&
                                      boot_pin_s && !boot_float_s;
  wire [31:0]           fetch_word;
  wire                  fetch_done;
  boot_word_fetch u_fetch (
    .clk         (clk),
    .rst         (rst),
    .start       (fetch_start),
    .word        (fetch_word),
    .done        (fetch_done),
    .eeprom_req  (eeprom_req),
    .eeprom_ack  (eeprom_ack),
    .eeprom_data (eeprom_data)
  );
  // apb decode
  wire apb_setup  = psel && !penable;
  wire apb_access = psel && penable;
  wire hit_ctrl   = (paddr == `GC_CTRL_OFF);
  wire hit_thr    = (paddr == `GC_THRESH_OFF);
  wire hit_status = (paddr == `GC_STATUS_OFF);
  wire mapped     = hit_ctrl || hit_thr || hit_status;
  wire wr_en      = apb_access && pwrite && done_q;
  wire [31:0] ctrl_rd = {{(32-`CTRL_W){1'b0}}, ctrl_q};
  wire [31:0] thr_rd  = {26'h000_0000, thr_q, 1'b0};
  wire [31:0] stat_rd = {27'h000_0000, auto_set_q, pad_en_q,
                         mode_q, done_q};
  wire [31:0] ctrl_wr = merge_lanes(ctrl_rd, pwdata, pstrb);
  wire [31:0] thr_wr  = merge_lanes(thr_rd, pwdata, pstrb);
  // auto keep-on sets on the rising edge of the reset output
  wire rst_out_rise = reset_output_level && !rst_out_q;
  wire auto_set     = done_q && ctrl_q[`CB_AUTO_KEEP_ON] &&
                      rst_out_rise; // [RULE17]
  // boot sequence
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_SETTLE: begin
        if (settle_q == `SETTLE_CYCLES) begin
          state_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        state_d = fetch_start ? ST_FETCH : ST_DONE; // [RULE1]
      end
      ST_FETCH: begin
        if (fetch_done) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_DONE;
      end
      default: begin
        state_d = ST_SETTLE;
      end
    endcase
  end
  // control word and threshold next values
  always @* begin
    ctrl_d = ctrl_q;
    thr_d  = thr_q;
    if (state_q == ST_SAMPLE && !fetch_start) begin
      ctrl_d = `CTRL_FIXED; // [RULE3] [RULE4] [RULE5] [RULE6] [RULE7]
      thr_d  = FIXED_THRESHOLD; // [RULE16]
    end else if (state_q == ST_FETCH && fetch_done) begin
      ctrl_d = fetch_word[`EE_CTRL_MSB:0]; // [RULE19]
      thr_d  = fetch_word[`EE_THR_MSB:`EE_THR_LSB];
    end else if (wr_en && hit_ctrl) begin
      ctrl_d = ctrl_wr[`CTRL_W-1:0]; // [RULE19]
    end else if (wr_en && hit_thr) begin
      thr_d = thr_wr[`THR_MSB:`THR_LSB]; // [RULE16]
    end
    if (auto_set) begin
      ctrl_d[`CB_KEEP_ON] = 1'b1; // [RULE17]
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      state_q    <= ST_SETTLE;
      settle_q   <= {`SETTLE_W{1'b0}};
      mode_q     <= `MODE_FIXED;
      pad_en_q   <= 1'b1;
      done_q     <= 1'b0;
      auto_set_q <= 1'b0;
      ctrl_q     <= `CTRL_FIXED;
      thr_q      <= FIXED_THRESHOLD;
      rst_out_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      ctrl_q    <= ctrl_d;
      thr_q     <= thr_d;
      rst_out_q <= reset_output_level;
      if (state_q == ST_SETTLE) begin
        settle_q <= settle_q + 1'b1;
      end
      if (state_q == ST_SAMPLE) begin
        pad_en_q <= 1'b0; // [RULE2]
        if (boot_float_s) begin
          mode_q <= `MODE_TEST;
        end else if (boot_pin_s) begin
          mode_q <= `MODE_EEPROM; // [RULE1]
        end else begin
          mode_q <= `MODE_FIXED; // [RULE1]
        end
      end
      if (state_d == ST_DONE) begin
        done_q <= 1'b1; // [RULE19]
      end
      if (auto_set) begin
        auto_set_q <= 1'b1;
      end
    end
  end
  // read data captured in the setup phase
  always @(posedge clk) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      if (hit_ctrl) begin
        prdata_q <= ctrl_rd;
      end else if (hit_thr) begin
        prdata_q <= thr_rd;
      end else if (hit_status) begin
        prdata_q <= stat_rd;
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end
  // consumers of the control word
  always @(posedge clk) begin
    if (rst) begin
      slot_q     <= SLOT_LONG_CYCLES;
      irq_out_q  <= 1'b1;
      sw_on_q    <= 1'b0;
      edge_irq_q <= 4'h0;
      pin0_out_q <= 1'b0;
      pin0_oe_q  <= 1'b1;
      hold_req_q <= 1'b0;
      hold_gpi_q <= 1'b0;
      pd_act_q   <= 1'b0;
    end else begin
      slot_q <= ctrl_q[`CB_SLOT_SEL] ? SLOT_LONG_CYCLES :
                                       SLOT_SHORT_CYCLES; // [RULE6]
      irq_out_q <= apply_pol(irq_pending,
                             ctrl_q[`CB_IRQ_POL]); // [RULE9]
      sw_on_q <= battery_high_event &&
                 !ctrl_q[`CB_BAT_HI_MASK]; // [RULE10]
      edge_irq_q <= {input_five_fall_event, input_five_rise_event,
                     input_four_fall_event, input_four_rise_event} &
                    ~ctrl_q[`CB_IN5_FALL_MASK:`CB_IN4_RISE_MASK];
                    // [RULE11] [RULE12]
      if (ctrl_q[`CB_PIN0_OD_SEL]) begin
        pin0_out_q <= 1'b0; // [RULE13]
        pin0_oe_q  <= !pin_zero_level;
      end else begin
        pin0_out_q <= pin_zero_level; // [RULE13]
        pin0_oe_q  <= 1'b1;
      end
      hold_req_q <= hold_pin_s && !ctrl_q[`CB_AUTO_KEEP_ON]; // [RULE17]
      hold_gpi_q <= hold_pin_s && ctrl_q[`CB_AUTO_KEEP_ON];
      pd_act_q   <= apply_pol(pd_pin_s, ctrl_q[`CB_PD_POL]); // [RULE18]
    end
  end
  assign pready  = 1'b1;
  assign pslverr = apb_access && !mapped;
  assign prdata  = prdata_q;
  assign boot_pad_enable    = pad_en_q;
  assign load_done          = done_q;
  assign slot_length_cycles = slot_q;
  assign rtc_regulator_off_mask        = ctrl_q[`CB_RTC_OFF_MASK];
  assign slow_clock_source_select      = ctrl_q[`CB_SLOW_CLK_SEL];
  assign keep_device_on                = ctrl_q[`CB_KEEP_ON]; // [RULE5]
  assign slot_duration_select          = ctrl_q[`CB_SLOT_SEL];
  assign long_press_power_off_enable   = ctrl_q[`CB_LP_OFF_EN];
  assign long_press_core_reset_enable  = ctrl_q[`CB_LP_RST_EN]; // [RULE8]
  assign interrupt_polarity_select     = ctrl_q[`CB_IRQ_POL];
  assign battery_high_switch_on_mask   = ctrl_q[`CB_BAT_HI_MASK];
  assign input_four_rise_mask          = ctrl_q[`CB_IN4_RISE_MASK];
  assign input_four_fall_mask          = ctrl_q[`CB_IN4_FALL_MASK];
  assign input_five_rise_mask          = ctrl_q[`CB_IN5_RISE_MASK];
  assign input_five_fall_mask          = ctrl_q[`CB_IN5_FALL_MASK];
  assign pin_zero_open_drain_select    = ctrl_q[`CB_PIN0_OD_SEL];
  assign watchdog_enable               = ctrl_q[`CB_WDOG_EN]; // [RULE14]
  assign battery_monitor_buffer_bypass = ctrl_q[`CB_BUF_BYPASS]; // [RULE15]
  assign battery_gate_threshold        = thr_q;
  assign auto_keep_on_select           = ctrl_q[`CB_AUTO_KEEP_ON];
  assign power_down_input_polarity     = ctrl_q[`CB_PD_POL];

  assign interrupt_output    = irq_out_q;
  assign switch_on_request   = sw_on_q;
  assign input_four_rise_irq = edge_irq_q[0];
  assign input_four_fall_irq = edge_irq_q[1];
  assign input_five_rise_irq = edge_irq_q[2];
  assign input_five_fall_irq = edge_irq_q[3];
  assign pin_zero_out        = pin0_out_q;
  assign pin_zero_oe         = pin0_oe_q;
  assign hold_request        = hold_req_q;
  assign hold_gpi_level      = hold_gpi_q;
  assign power_down_active   = pd_act_q;

endmodule // boot_general_control_loader

`default_nettype wire

// *** test/eeprom_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module eeprom_model #(
  parameter int DELAY = 3
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // fetch handshake
  input  wire logic        eeprom_req,
  input  wire logic [31:0] word,
  output logic             eeprom_ack,
  output logic [31:0]      eeprom_data
);
  int n;

  // data toggles while idle so a stale word never looks valid
  always @(posedge clk) begin
    if (rst || !eeprom_req || eeprom_ack) begin
      eeprom_ack  <= 1'b0;
      eeprom_data <= ~eeprom_data;
      n           <= 0;
    end else if (n == DELAY) begin
      eeprom_ack  <= 1'b1;
      eeprom_data <= word;
    end else begin
      n           <= n + 1;
      eeprom_data <= ~eeprom_data;
    end
  end

  initial eeprom_data = 32'h5555_aaaa;
endmodule // eeprom_model
`default_nettype wire

// *** test/boot_general_control_loader_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "boot_loader_regs.vh"

module loader_checker #(
  parameter [`SLOT_CNT_W-1:0] SLOT_SHORT_CYCLES = 1,
  parameter [`SLOT_CNT_W-1:0] SLOT_LONG_CYCLES  = 2
) (
  // clock and reset
  input wire logic clk, rst,
  // boot and fetch
  input wire logic boot_pad_enable, load_done, eeprom_req, eeprom_ack,
  // control bits
  input wire logic interrupt_polarity_select, battery_high_switch_on_mask,
  input wire logic input_four_rise_mask, input_four_fall_mask,
  input wire logic input_five_rise_mask, input_five_fall_mask,
  input wire logic pin_zero_open_drain_select, slot_duration_select,
  input wire logic auto_keep_on_select, keep_device_on,
  input wire logic [`SLOT_CNT_W-1:0] slot_length_cycles,
  // event side
  input wire logic irq_pending, interrupt_output, reset_output_level,
  input wire logic battery_high_event, switch_on_request,
  input wire logic input_four_rise_event, input_four_fall_event,
  input wire logic input_five_rise_event, input_five_fall_event,
  input wire logic input_four_rise_irq, input_four_fall_irq,
  input wire logic input_five_rise_irq, input_five_fall_irq,
  input wire logic pin_zero_level, pin_zero_out, pin_zero_oe,
  input wire logic supply_hold_pin, hold_request, hold_gpi_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_slot_still;
    $stable(slot_duration_select) [*2];
  endsequence
  sequence s_hold_still;
    ($stable(supply_hold_pin) && $stable(auto_keep_on_select)) [*4];
  endsequence

  AST_PAD_OFF: assert property (load_done |-> !boot_pad_enable)
    else $error("pad on after load");
  AST_PAD_STAYS: assert property (!boot_pad_enable |=> !boot_pad_enable)
    else $error("pad came back on");
  AST_IRQ_POL: assert property (!$past(rst) |-> interrupt_output ==
    ($past(interrupt_polarity_select) ? $past(irq_pending)
                                      : !$past(irq_pending)))
    else $error("interrupt level wrong");
  AST_SWITCH_ON: assert property (!$past(rst) |-> switch_on_request ==
    $past(battery_high_event && !battery_high_switch_on_mask))
    else $error("switch on request wrong");
  AST_EDGE_IRQ: assert property (!$past(rst) |->
    {input_four_rise_irq, input_four_fall_irq, input_five_rise_irq,
     input_five_fall_irq} == $past({input_four_rise_event,
     input_four_fall_event, input_five_rise_event, input_five_fall_event}
     & ~{input_four_rise_mask, input_four_fall_mask, input_five_rise_mask,
     input_five_fall_mask}))
    else $error("edge interrupt wrong");
  AST_PIN_ZERO: assert property (!$past(rst) |->
    pin_zero_oe == ($past(pin_zero_open_drain_select) ?
    !$past(pin_zero_level) : 1'b1) && pin_zero_out ==
    ($past(pin_zero_open_drain_select) ? 1'b0 : $past(pin_zero_level)))
    else $error("pin zero drive wrong");
  AST_SLOT: assert property (s_slot_still |-> slot_length_cycles ==
    (slot_duration_select ? SLOT_LONG_CYCLES : SLOT_SHORT_CYCLES))
    else $error("slot length wrong");
  AST_REQ_HOLD: assert property (eeprom_req && !eeprom_ack |=> eeprom_req)
    else $error("fetch request dropped");
  AST_LOAD: assert property (eeprom_req && eeprom_ack |-> ##2 load_done)
    else $error("load late after fetch");
  AST_AUTO_ON: assert property (load_done && auto_keep_on_select &&
    $rose(reset_output_level) |=> keep_device_on)
    else $error("auto keep on missed");
  AST_HOLD: assert property (s_hold_still |->
    hold_request == (supply_hold_pin && !auto_keep_on_select) &&
    hold_gpi_level == (supply_hold_pin && auto_keep_on_select))
    else $error("hold pin role wrong");
endmodule // loader_checker

bind boot_general_control_loader loader_checker #(
  .SLOT_SHORT_CYCLES(SLOT_SHORT_CYCLES),
  .SLOT_LONG_CYCLES(SLOT_LONG_CYCLES)
) chk_i (.*);
`default_nettype wire

// *** test/boot_general_control_loader_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "boot_loader_regs.vh"

module boot_general_control_loader_tb;
  logic clk, rst, psel, penable, pwrite, boot_select_pin, boot_pin_floating;
  logic [7:0] paddr;
  logic [31:0] pwdata, ee_word, rd;
  logic [3:0] pstrb;
  logic reset_output_level, irq_pending, battery_high_event, pin_zero_level;
  logic input_four_rise_event, input_four_fall_event, supply_hold_pin;
  logic input_five_rise_event, input_five_fall_event, power_down_reset_input;
  wire [31:0] prdata, eeprom_data;
  wire [16:0] slot_length_cycles;
  wire [4:0] battery_gate_threshold;
  wire pready, pslverr, boot_pad_enable, eeprom_req, eeprom_ack, load_done;
  wire rtc_regulator_off_mask, slow_clock_source_select, keep_device_on;
  wire slot_duration_select, long_press_power_off_enable;
  wire long_press_core_reset_enable, interrupt_polarity_select;
  wire battery_high_switch_on_mask, input_four_rise_mask, input_four_fall_mask;
  wire input_five_rise_mask, input_five_fall_mask, pin_zero_open_drain_select;
  wire watchdog_enable, battery_monitor_buffer_bypass, auto_keep_on_select;
  wire power_down_input_polarity, interrupt_output, switch_on_request;
  wire input_four_rise_irq, input_four_fall_irq, input_five_rise_irq;
  wire input_five_fall_irq, pin_zero_out, pin_zero_oe, hold_request;
  wire hold_gpi_level, power_down_active;
  wire [16:0] cw = {power_down_input_polarity, auto_keep_on_select,
    battery_monitor_buffer_bypass, watchdog_enable, pin_zero_open_drain_select,
    input_five_fall_mask, input_five_rise_mask, input_four_fall_mask,
    input_four_rise_mask, battery_high_switch_on_mask,
    interrupt_polarity_select, long_press_core_reset_enable,
    long_press_power_off_enable, slot_duration_select, keep_device_on,
    slow_clock_source_select, rtc_regulator_off_mask};
  wire [3:0] eirq = {input_four_rise_irq, input_four_fall_irq,
    input_five_rise_irq, input_five_fall_irq};
  // bits 0, 1, 2, 6, 8, 10, 12 and 16 stay clear in the fixed word
  localparam logic [16:0] FIX = 17'h0
    | (17'h1 << `CB_SLOT_SEL)
    | (17'h1 << `CB_LP_OFF_EN)
    | (17'h1 << `CB_LP_RST_EN)
    | (17'h1 << `CB_BAT_HI_MASK)
    | (17'h1 << `CB_IN4_FALL_MASK)
    | (17'h1 << `CB_IN5_FALL_MASK)
    | (17'h1 << `CB_WDOG_EN)
    | (17'h1 << `CB_BUF_BYPASS)
    | (17'h1 << `CB_AUTO_KEEP_ON);
  int failures, compares;
  logic err;
  logic m;

  boot_general_control_loader #(
    .SLOT_SHORT_CYCLES(17'd20),
    .SLOT_LONG_CYCLES(17'd80)
  ) dut (.*);

  eeprom_model #(.DELAY(3)) ee (.clk(clk), .rst(rst),
    .eeprom_req(eeprom_req), .word(ee_word), .eeprom_ack(eeprom_ack),
    .eeprom_data(eeprom_data));

  always #12.5 clk = ~clk;

  task end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      failures++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  task boot(input logic sel, input logic fl);
    int i;
    boot_select_pin <= sel; boot_pin_floating <= fl; rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 200 && load_done !== 1'b1; i++) @(posedge clk);
    if (load_done !== 1'b1) begin
      failures++;
      end_sim();
    end
    @(posedge clk);
    chk("pad", boot_pad_enable, 0);
  endtask

  task stim(input logic v);
    {irq_pending, battery_high_event, input_four_rise_event,
     input_four_fall_event, input_five_rise_event, input_five_fall_event,
     pin_zero_level, supply_hold_pin, power_down_reset_input} <= {9{v}};
    repeat (6) @(posedge clk);
  endtask

  initial begin
    clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; pstrb = 4'hf; boot_select_pin = 0; boot_pin_floating = 0;
    reset_output_level = 0; ee_word = {3'h0, 5'h13, 7'h0, 17'h1_5147};
    {irq_pending, battery_high_event, input_four_rise_event,
     input_four_fall_event, input_five_rise_event, input_five_fall_event,
     pin_zero_level, supply_hold_pin, power_down_reset_input} = 9'h000;
    failures = 0; compares = 0;
    @(posedge clk);
    boot(1'b0, 1'b0);
    chk("fixed word", cw, FIX);
    chk("slot long", slot_length_cycles, 80);
    chk("fixed thr", battery_gate_threshold, 5'h0c);
    apb(1'b0, `GC_STATUS_OFF, 0);
    chk("status fixed", rd, 32'h0000_0001);
    boot(1'b1, 1'b0);
    chk("eeprom word", cw, 17'h1_5147);
    chk("eeprom thr", battery_gate_threshold, 5'h13);
    chk("slot short", slot_length_cycles, 20);
    apb(1'b0, `GC_THRESH_OFF, 0);
    chk("thr reg", rd, 32'h0000_0026);
    apb(1'b0, `GC_STATUS_OFF, 0);
    chk("status eeprom", rd, 32'h0000_0003);
    boot(1'b0, 1'b1);
    chk("test word", cw, FIX);
    apb(1'b0, `GC_STATUS_OFF, 0);
    chk("status test", rd, 32'h0000_0005);
    for (int k = 0; k < 2; k++) begin
      m = k[0];
      apb(1'b1, `GC_CTRL_OFF, {32{m}});
      apb(1'b0, `GC_CTRL_OFF, 0);
      chk("ctrl rw", rd, {15'h0, {17{m}}});
      stim(1'b1);
      chk("int out", interrupt_output, m);
      chk("switch on", switch_on_request, !m);
      chk("edge irq", eirq, {4{!m}});
      chk("pin zero", {pin_zero_out, pin_zero_oe}, m ? 2'b00 : 2'b11);
      chk("hold req", hold_request, !m);
      chk("hold gpi", hold_gpi_level, m);
      chk("pd active", power_down_active, m);
      chk("slot len", slot_length_cycles, m ? 80 : 20);
      stim(1'b0);
      chk("pd idle", power_down_active, !m);
    end
    apb(1'b1, `GC_CTRL_OFF, 32'h0001_fffb);
    chk("keep clr", keep_device_on, 0);
    reset_output_level <= 1'b1;
    repeat (3) @(posedge clk);
    chk("auto keep", keep_device_on, 1);
    apb(1'b1, `GC_STATUS_OFF, 0);
    apb(1'b0, `GC_STATUS_OFF, 0);
    chk("status ro", rd, 32'h0000_0015);
    apb(1'b0, 8'h0c, 0);
    chk("unmapped", err, 1);
    chk("unmapped rd", rd, 0);
    end_sim();
  end

  initial begin
    #1000000;
    failures++;
    end_sim();
  end
endmodule // boot_general_control_loader_tb
`default_nettype wire
